// file: adc_ctrl_pkg.sv
package adc_ctrl_pkg;
  localparam int RES_W = 10;
  localparam logic [11:0] ADDR_CTRL0 = 12'h000;
  localparam logic [11:0] ADDR_CTRL1 = 12'h004;
  localparam logic [11:0] ADDR_RES_HI = 12'h008;
  localparam logic [11:0] ADDR_RES_LO = 12'h00C;
  localparam logic [11:0] ADDR_TRIG = 12'h010;
  localparam logic [11:0] ADDR_FLAG = 12'h014;
  localparam logic [11:0] ADDR_IRQ = 12'h018;
  localparam logic [11:0] ADDR_STAT = 12'h01C;
  // control 0 fields
  localparam int C0_ON = 0;
  localparam int C0_GO = 1;
  localparam int C0_CHS = 2;
  // control 1 fields
  localparam int C1_PREF = 0;
  localparam int C1_NREF = 2;
  localparam int C1_CS = 4;
  localparam int C1_FM = 7;
  // irq control fields
  localparam int IRQ_IE = 0;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE = 1;
  localparam int IRQ_GIE = 2;
  localparam logic [1:0] CS_RC = 2'h3;
  // bit-period divisor index: 000=/2 001=/8 010=/32 100=/4 101=/16 110=/64
  localparam int SAMPLE_HALVES = 3;
  localparam int BIT_HALVES = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_SAMPLE, ST_CONV} conv_state_t;
endpackage : adc_ctrl_pkg

// file: clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// makes one tick per half bit period from the system or rc clock enable
module clk_div
  import adc_ctrl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [2:0] sel,
  input wire logic rc_tick,
  output logic half_tick
);
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic [5:0] lim;
  logic half_nxt;
  always_comb
  begin
    case (sel)
      3'h0: lim = 6'h00;
      3'h4: lim = 6'h01;
      3'h1: lim = 6'h03;
      3'h5: lim = 6'h07;
      3'h2: lim = 6'h0F;
      3'h6: lim = 6'h1F;
      default: lim = 6'h00;
    endcase
    cnt_nxt = cnt_r;
    half_nxt = 1'b0;
    if (!run)
      cnt_nxt = 6'h00;
    else if (sel[1:0] == CS_RC)
      half_nxt = rc_tick;
    else if (cnt_r >= lim)
    begin
      cnt_nxt = 6'h00;
      half_nxt = 1'b1;
    end
    else
      cnt_nxt = cnt_r + 6'h01;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r <= 6'h00;
      half_tick <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      half_tick <= half_nxt;
    end
  end
endmodule : clk_div
`default_nettype wire

// file: sar_step.sv
`timescale 1ns/1ps
`default_nettype none
// successive approximation register, msb first
module sar_step
  import adc_ctrl_pkg::*;
#(
  parameter int W = RES_W
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic step,
  input wire logic comp_hi,
  output logic [W-1:0] trial,
  output logic [W-1:0] pos,
  output logic [W-1:0] partial
);
  logic [W-1:0] trial_nxt;
  logic [W-1:0] pos_nxt;
  logic [W-1:0] part_c;
  logic last_bit;
  always_comb
  begin
    trial_nxt = trial;
    pos_nxt = pos;
    last_bit = 1'b0;
    part_c = '0;
    if (start)
    begin
      trial_nxt = '0;
      trial_nxt[W-1] = 1'b1;
      pos_nxt = '0;
      pos_nxt[W-1] = 1'b1;
    end
    else if (step && pos != '0)
    begin
      trial_nxt = comp_hi ? trial : (trial & ~pos);
      trial_nxt = trial_nxt | (pos >> 1);
      pos_nxt = pos >> 1;
    end
    // unresolved bits copy the last resolved bit
    for (int i = W - 1; i >= 0; i--)
    begin
      if (pos[i])
        part_c[i] = last_bit;
      else if (pos > (W'(1) << i))
        part_c[i] = last_bit;
      else
      begin
        part_c[i] = trial[i];
        last_bit = trial[i];
      end
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trial <= '0;
      pos <= '0;
      partial <= '0;
    end
    else
    begin
      trial <= trial_nxt;
      pos <= pos_nxt;
      partial <= part_c;
    end
  end
endmodule : sar_step
`default_nettype wire

// file: sar_adc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int TRIG_N = 16,
  parameter int INSTR_CYCLES = 4
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_active,
  input wire logic rc_tick,
  input wire logic comp_hi,
  input wire logic [TRIG_N-1:0] trig_in,
  output logic [5:0] channel_select,
  output logic [1:0] pos_ref_select,
  output logic neg_ref_select,
  output logic [9:0] dac_trial,
  output logic sample_hold,
  output logic analog_on,
  output logic conv_done_flag,
  output logic wake_req,
  output logic vector_req
);
  import adc_ctrl_pkg::*;
  logic [7:0] ctrl0_r, ctrl0_nxt, ctrl1_r, ctrl1_nxt, res_hi_r, res_hi_nxt, res_lo_r, res_lo_nxt;
  logic [3:0] trig_sel_r, trig_sel_nxt;
  logic [2:0] irq_r, irq_nxt;
  logic flag_nxt, off_r, off_nxt, trig_q_r, trig_q_nxt;
  conv_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] dly_r, dly_nxt;
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [11:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_nxt, rresp_nxt;
  logic bvalid_nxt, rvalid_nxt;
  logic half_tick, sar_start, sar_step_en, finish, abort;
  logic [9:0] trial, pos, partial, result;
  logic do_wr, go_set, go_clr_sw, flag_clr, trig_now;
  logic [7:0] w0, w1;
  logic [5:0] chs_nxt;
  logic [1:0] pref_nxt;
  logic nref_nxt, sample_nxt, on_nxt, wake_nxt, vec_nxt;

  clk_div u_div (
    .aclk(aclk), .aresetn(aresetn), .run(st_r == ST_SAMPLE || st_r == ST_CONV),
    .sel(ctrl1_r[C1_CS +: 3]), .rc_tick(rc_tick), .half_tick(half_tick)
  );
  sar_step #(.W(RES_W)) u_sar (
    .aclk(aclk), .aresetn(aresetn), .start(sar_start), .step(sar_step_en),
    .comp_hi(comp_hi), .trial(trial), .pos(pos), .partial(partial)
  );

  always_comb
  begin
    // bus write path: address and data taken in either order
    aw_hold_nxt = aw_hold_r | (s_axi_awvalid & s_axi_awready);
    w_hold_nxt = w_hold_r | (s_axi_wvalid & s_axi_wready);
    awaddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_r;
    wdata_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_r;
    do_wr = aw_hold_r & w_hold_r & ~s_axi_bvalid;
    bvalid_nxt = s_axi_bvalid & ~s_axi_bready;
    bresp_nxt = s_axi_bresp;
    if (do_wr)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (awaddr_r[11:2] <= ADDR_STAT[11:2]) ? RESP_OKAY : RESP_SLVERR;
    end
    w0 = wdata_r[7:0];
    w1 = wstrb_r[0] ? w0 : 8'h00;
    go_set = 1'b0;
    go_clr_sw = 1'b0;
    flag_clr = 1'b0;
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    trig_sel_nxt = trig_sel_r;
    irq_nxt = irq_r;
    if (do_wr && wstrb_r[0])
    begin
      case (awaddr_r)
        ADDR_CTRL0:
        begin
          ctrl0_nxt[7:2] = w0[7:2];
          ctrl0_nxt[C0_ON] = w0[C0_ON];
          go_set = w0[C0_GO] & ctrl0_r[C0_ON];
          go_clr_sw = ~w0[C0_GO] & ctrl0_r[C0_GO];
        end
        ADDR_CTRL1: ctrl1_nxt = w1;
        ADDR_TRIG: trig_sel_nxt = w0[3:0];
        ADDR_FLAG: flag_clr = ~w0[0];
        ADDR_IRQ: irq_nxt = w0[2:0];
        default: ;
      endcase
    end
    // rising edge of chosen trigger
    trig_now = trig_in[trig_sel_r] & ~trig_q_r;
    trig_q_nxt = trig_in[trig_sel_r];
    if (trig_now && ctrl0_r[C0_ON])
      go_set = 1'b1;

    st_nxt = st_r;
    cnt_nxt = cnt_r;
    dly_nxt = dly_r;
    sar_start = 1'b0;
    sar_step_en = 1'b0;
    finish = 1'b0;
    abort = 1'b0;
    off_nxt = off_r;
    if (!sleep_active)
      off_nxt = 1'b0;
    case (st_r)
      ST_IDLE:
        if (go_set && !off_r)
        begin
          ctrl0_nxt[C0_GO] = 1'b1;
          dly_nxt = 8'(INSTR_CYCLES);
          st_nxt = (ctrl1_r[C1_CS +: 2] == CS_RC) ? ST_DELAY : ST_SAMPLE;
          sar_start = 1'b1;
          cnt_nxt = 4'h0;
        end
      ST_DELAY:
        if (dly_r <= 8'h01)
          st_nxt = ST_SAMPLE;
        else
          dly_nxt = dly_r - 8'h01;
      ST_SAMPLE:
        if (half_tick)
        begin
          // 1.5 bit periods of sampling then ten decisions give 11.5
          if (cnt_r == 4'(SAMPLE_HALVES - 1))
          begin
            st_nxt = ST_CONV;
            cnt_nxt = 4'h0;
          end
          else
            cnt_nxt = cnt_r + 4'h1;
        end
      ST_CONV:
        if (half_tick)
        begin
          cnt_nxt = cnt_r + 4'h1;
          if (cnt_r[0])
          begin
            sar_step_en = 1'b1;
            if (pos[0])
              finish = 1'b1;
          end
        end
      default: st_nxt = ST_IDLE;
    endcase
    if (st_r != ST_IDLE)
    begin
      if (go_clr_sw || !ctrl0_nxt[C0_ON])
        abort = 1'b1;
      else if (sleep_active && ctrl1_r[C1_CS +: 2] != CS_RC)
      begin
        abort = 1'b1;
        off_nxt = 1'b1;
      end
    end
    result = finish ? (comp_hi ? trial : (trial & ~pos)) : partial;
    res_hi_nxt = res_hi_r;
    res_lo_nxt = res_lo_r;
    flag_nxt = conv_done_flag & ~flag_clr;
    if (finish || abort)
    begin
      st_nxt = ST_IDLE;
      ctrl0_nxt[C0_GO] = 1'b0;
      if (ctrl1_r[C1_FM])
      begin
        res_hi_nxt = {6'h00, result[9:8]};
        res_lo_nxt = result[7:0];
      end
      else
      begin
        res_hi_nxt = result[9:2];
        res_lo_nxt = {result[1:0], 6'h00};
      end
    end
    if (finish)
    begin
      flag_nxt = 1'b1;
      if (sleep_active && !irq_r[IRQ_IE])
        off_nxt = 1'b1;
    end
    chs_nxt = ctrl0_r[C0_CHS +: 6];
    pref_nxt = ctrl1_r[C1_PREF +: 2];
    nref_nxt = ctrl1_r[C1_NREF];
    sample_nxt = (st_nxt == ST_SAMPLE) || (st_nxt == ST_DELAY);
    on_nxt = ctrl0_nxt[C0_ON] & ~off_nxt;
    wake_nxt = sleep_active & flag_nxt & irq_r[IRQ_IE] & irq_r[IRQ_PERIPHERAL_IRQ_ENABLE];
    vec_nxt = flag_nxt & irq_r[IRQ_IE] & irq_r[IRQ_PERIPHERAL_IRQ_ENABLE] & irq_r[IRQ_GIE];

    rvalid_nxt = s_axi_rvalid & ~s_axi_rready;
    rdata_nxt = s_axi_rdata;
    rresp_nxt = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL0: rdata_nxt = {24'h000000, ctrl0_r};
        ADDR_CTRL1: rdata_nxt = {24'h000000, ctrl1_r};
        ADDR_RES_HI: rdata_nxt = {24'h000000, res_hi_r};
        ADDR_RES_LO: rdata_nxt = {24'h000000, res_lo_r};
        ADDR_TRIG: rdata_nxt = {28'h0000000, trig_sel_r};
        ADDR_FLAG: rdata_nxt = {31'h00000000, conv_done_flag};
        ADDR_IRQ: rdata_nxt = {29'h00000000, irq_r};
        ADDR_STAT: rdata_nxt = {30'h00000000, off_r, ctrl0_r[C0_GO]};
        default:
        begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl0_r <= 8'h00;
      ctrl1_r <= 8'h00;
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
      trig_sel_r <= 4'h0;
      irq_r <= 3'h0;
      conv_done_flag <= 1'b0;
      off_r <= 1'b0;
      trig_q_r <= 1'b0;
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      dly_r <= 8'h00;
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      channel_select <= 6'h00;
      pos_ref_select <= 2'h0;
      neg_ref_select <= 1'b0;
      dac_trial <= 10'h000;
      sample_hold <= 1'b0;
      analog_on <= 1'b0;
      wake_req <= 1'b0;
      vector_req <= 1'b0;
    end
    else
    begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      res_hi_r <= res_hi_nxt;
      res_lo_r <= res_lo_nxt;
      trig_sel_r <= trig_sel_nxt;
      irq_r <= irq_nxt;
      conv_done_flag <= flag_nxt;
      off_r <= off_nxt;
      trig_q_r <= trig_q_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      dly_r <= dly_nxt;
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt & ~(s_axi_wvalid & s_axi_wready);
      s_axi_arready <= ~rvalid_nxt & ~(s_axi_arvalid & s_axi_arready);
      s_axi_bvalid <= bvalid_nxt;
      s_axi_bresp <= bresp_nxt;
      s_axi_rvalid <= rvalid_nxt;
      s_axi_rresp <= rresp_nxt;
      s_axi_rdata <= rdata_nxt;
      channel_select <= chs_nxt;
      pos_ref_select <= pref_nxt;
      neg_ref_select <= nref_nxt;
      dac_trial <= trial;
      sample_hold <= sample_nxt;
      analog_on <= on_nxt;
      wake_req <= wake_nxt;
      vector_req <= vec_nxt;
    end
  end
endmodule : sar_adc_ctrl
`default_nettype wire

// file: sar_adc_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_active,
  input wire logic [5:0] channel_select,
  input wire logic [9:0] dac_trial,
  input wire logic sample_hold,
  input wire logic conv_done_flag,
  input wire logic wake_req,
  input wire logic vector_req
);
  wire logic wr_hs = s_axi_wvalid && s_axi_wready;
  wire logic clr_hs = wr_hs && !s_axi_wdata[0];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_flag_sticky;
    $fell(conv_done_flag) |-> $past(clr_hs) || $past(clr_hs, 2) || $past(clr_hs, 3);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag fell without clear");
  property p_wake;
    wake_req |-> conv_done_flag && $past(sleep_active);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without done in sleep");
  property p_vector;
    vector_req |-> conv_done_flag;
  endproperty
  a_vector: assert property (p_vector) else $error("vector without done");
  property p_done_end;
    $rose(conv_done_flag) |-> !sample_hold;
  endproperty
  a_done_end: assert property (p_done_end) else $error("done while sampling");
  property p_msb_first;
    $fell(sample_hold) && !sleep_active |-> ##[0:2] dac_trial == 10'h200;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
  property p_chs_write;
    $changed(channel_select) |-> $past(wr_hs) || $past(wr_hs, 2) || $past(wr_hs, 3);
  endproperty
  a_chs_write: assert property (p_chs_write) else $error("channel changed alone");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  c_done: cover property ($rose(conv_done_flag));
  c_wake: cover property ($rose(wake_req));
  c_vector: cover property ($rose(vector_req));
endmodule : sar_adc_ctrl_chk
bind sar_adc_ctrl sar_adc_ctrl_chk u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .sleep_active(sleep_active),
  .channel_select(channel_select),
  .dac_trial(dac_trial),
  .sample_hold(sample_hold),
  .conv_done_flag(conv_done_flag),
  .wake_req(wake_req),
  .vector_req(vector_req)
);
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import adc_ctrl_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic sleep_active = 1'b0;
  logic rc_tick = 1'b0;
  logic comp_hi;
  logic [15:0] trig_in = 16'h0;
  logic [5:0] channel_select;
  logic [1:0] pos_ref_select;
  logic neg_ref_select;
  logic [9:0] dac_trial;
  logic sample_hold, analog_on, conv_done_flag, wake_req, vector_req;
  logic [9:0] vin = 10'h0;
  logic [2:0] rc_cnt = 3'h0;
  logic [31:0] rd, hs;
  logic [1:0] rsp;
  logic [5:0] chs = 6'h0;
  logic [1:0] pr = 2'h0;
  logic nr = 1'b0;
  logic fm = 1'b1;
  logic [2:0] cs;
  int fails = 0;
  int cmp_count = 0;
  int ncyc = 0;
  int t0, cyc, h, k;
  sar_adc_ctrl u_dut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .sleep_active(sleep_active),
    .rc_tick(rc_tick),
    .comp_hi(comp_hi),
    .trig_in(trig_in),
    .channel_select(channel_select),
    .pos_ref_select(pos_ref_select),
    .neg_ref_select(neg_ref_select),
    .dac_trial(dac_trial),
    .sample_hold(sample_hold),
    .analog_on(analog_on),
    .conv_done_flag(conv_done_flag),
    .wake_req(wake_req),
    .vector_req(vector_req)
  );
  // comparator: analog input at or above the trial code
  assign comp_hi = (vin >= dac_trial);
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // rc clock: one tick per 5 system cycles, free running
  always @(posedge aclk)
  begin
    rc_cnt <= (rc_cnt == 3'h4) ? 3'h0 : rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h4);
    ncyc <= ncyc + 1;
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic timeout();
    fails++;
    stop_test();
  endtask : timeout
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // handshakes are sampled at the falling edge, signals change after the rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic ta, tw, tb;
    n = 0;
    tb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    while (!tb)
    begin
      @(negedge aclk);
      ta = w ? s_axi_awready : s_axi_arready;
      tw = s_axi_wready;
      tb = w ? s_axi_bvalid : s_axi_rvalid;
      rsp = w ? s_axi_bresp : s_axi_rresp;
      rd = s_axi_rdata;
      @(posedge aclk);
      if (ta && w) s_axi_awvalid <= 1'b0;
      if (ta && !w) s_axi_arvalid <= 1'b0;
      if (tw && w) s_axi_wvalid <= 1'b0;
      if (tb && w) s_axi_bready <= 1'b0;
      if (tb && !w) s_axi_rready <= 1'b0;
      if (++n > 200) timeout();
    end
  endtask : bus
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask : rdchk
  task automatic start(input logic [2:0] c);
    bus(1'b1, ADDR_CTRL1, {24'h0, fm, c, 1'b0, nr, pr});
    bus(1'b1, ADDR_CTRL0, {24'h0, chs, 2'b01});
    // acquisition time after a channel change, before go
    repeat (8) @(posedge aclk);
    bus(1'b1, ADDR_CTRL0, {24'h0, chs, 2'b11});
    t0 = ncyc;
  endtask : start
  task automatic wait_flag();
    int n;
    n = 0;
    while (conv_done_flag !== 1'b1)
    begin
      @(negedge aclk);
      if (++n > 3000) timeout();
    end
    cyc = ncyc - t0;
  endtask : wait_flag
  task automatic rst_chk();
    for (int a = 0; a < 32; a += 4) rdchk("reset value", 12'(a), 32'h0);
    chk("flag reset", 1'b0, conv_done_flag);
  endtask : rst_chk
  function automatic logic [31:0] ehi(logic [9:0] v, logic f);
    return f ? {30'h0, v[9:8]} : {24'h0, v[9:2]};
  endfunction : ehi
  function automatic logic [31:0] elo(logic [9:0] v, logic f);
    return f ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0};
  endfunction : elo
  // true if the top bits match and the k lowest copy the last resolved bit
  function automatic logic part_ok(logic [9:0] r, logic [9:0] v);
    logic ok;
    ok = 1'b0;
    for (int i = 1; i < 10; i++)
      if ((r >> i) == (v >> i) && (r & ((10'h1 << i) - 10'h1)) == (r[i] ? (10'h1 << i) - 10'h1 : 10'h0))
        ok = 1'b1;
    return ok;
  endfunction : part_ok
  initial
  begin
    void'($urandom(32'hC1165C01));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rst_chk();
    bus(1'b0, 12'h020, 32'h0);
    chk("bad read resp", RESP_SLVERR, rsp);
    chk("bad read data", 32'h0, rd);
    bus(1'b1, 12'h020, 32'hFF);
    chk("bad write resp", RESP_SLVERR, rsp);
    bus(1'b1, ADDR_CTRL0, 32'h2);
    rdchk("go while off", ADDR_STAT, 32'h0);
    bus(1'b1, ADDR_CTRL0, 32'h3);
    rdchk("go with enable", ADDR_STAT, 32'h0);
    rdchk("enable only", ADDR_CTRL0, 32'h1);
    for (int i = 0; i < 16; i++)
    begin
      cs = i[2:0];
      vin <= (i == 0) ? 10'h0 : (i == 1) ? 10'h3FF : 10'($urandom);
      chs = 6'($urandom);
      pr = 2'($urandom);
      nr = 1'($urandom);
      fm = 1'($urandom);
      h = (cs[1:0] == 2'h3) ? 5 : (1 << (2 * cs[1:0] + cs[2]));
      start(cs);
      rdchk("busy", ADDR_STAT, 32'h1);
      wait_flag();
      chk("conv time", 1'b1, cyc >= 23 * h - 4 && cyc <= 23 * h + 16);
      rdchk("ctrl1", ADDR_CTRL1, {24'h0, fm, cs, 1'b0, nr, pr});
      rdchk("go at end", ADDR_CTRL0, {24'h0, chs, 2'b01});
      rdchk("result hi", ADDR_RES_HI, ehi(vin, fm));
      rdchk("result lo", ADDR_RES_LO, elo(vin, fm));
      @(negedge aclk);
      chk("channel", chs, channel_select);
      chk("pos ref", pr, pos_ref_select);
      chk("neg ref", nr, neg_ref_select);
      chk("analog on", 1'b1, analog_on);
      bus(1'b1, ADDR_FLAG, 32'h1);
      rdchk("flag kept", ADDR_FLAG, 32'h1);
      bus(1'b1, ADDR_FLAG, 32'h0);
      rdchk("flag cleared", ADDR_FLAG, 32'h0);
    end
    fm = 1'b1;
    vin <= 10'($urandom);
    start(3'h6);
    repeat (300) @(posedge aclk);
    bus(1'b1, ADDR_CTRL0, {24'h0, chs, 2'b01});
    bus(1'b0, ADDR_RES_HI, 32'h0);
    hs = rd;
    bus(1'b0, ADDR_RES_LO, 32'h0);
    chk("partial", 1'b1, part_ok({hs[1:0], rd[7:0]}, vin));
    rdchk("abort busy", ADDR_STAT, 32'h0);
    bus(1'b1, ADDR_FLAG, 32'h0);
    k = $urandom % 16;
    bus(1'b1, ADDR_TRIG, k);
    trig_in <= 16'h1 << (k ^ 1);
    repeat (4) @(posedge aclk);
    rdchk("other trigger", ADDR_STAT, 32'h0);
    trig_in <= (16'h1 << k) | (16'h1 << (k ^ 1));
    repeat (4) @(posedge aclk);
    rdchk("trigger", ADDR_STAT, 32'h1);
    wait_flag();
    trig_in <= 16'h0;
    bus(1'b1, ADDR_FLAG, 32'h0);
    bus(1'b1, ADDR_IRQ, 32'h3);
    start(3'h3);
    sleep_active <= 1'b1;
    wait_flag();
    repeat (2) @(negedge aclk);
    chk("wake", 1'b1, wake_req);
    chk("no vector", 1'b0, vector_req);
    bus(1'b1, ADDR_IRQ, 32'h7);
    @(negedge aclk);
    chk("vector", 1'b1, vector_req);
    sleep_active <= 1'b0;
    bus(1'b1, ADDR_FLAG, 32'h0);
    bus(1'b1, ADDR_IRQ, 32'h0);
    start(3'h7);
    sleep_active <= 1'b1;
    wait_flag();
    repeat (2) @(negedge aclk);
    chk("off after done", 1'b0, analog_on);
    rdchk("enable kept", ADDR_CTRL0, {24'h0, chs, 2'b01});
    sleep_active <= 1'b0;
    bus(1'b1, ADDR_FLAG, 32'h0);
    start(3'h5);
    repeat (20) @(posedge aclk);
    sleep_active <= 1'b1;
    repeat (3) @(negedge aclk);
    chk("off in sleep", 1'b0, analog_on);
    rdchk("forced off", ADDR_STAT, 32'h2);
    rdchk("enable set", ADDR_CTRL0, {24'h0, chs, 2'b01});
    sleep_active <= 1'b0;
    bus(1'b1, ADDR_FLAG, 32'h0);
    start(3'h6);
    repeat (200) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rst_chk();
    chk("off after reset", 1'b0, analog_on);
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
